//--- verilog/ief_pkg.sv
// constants and carriers for the integrity error flag bank
// assumes one 50 MHz clock shared with the serial host controller
// Behaviour
// - read of an unmapped address sets the host-read-fault flag.
// - write to an unmapped address sets the host-write-fault flag.
// - failed frame checksum from the serial link sets link-checksum-fault.
// - while enabled, map checksum is recomputed at a regular interval.
// - map changed without a host write sets map_checksum_fault.
// - ROM checksum computed after power-up, result in flag bit 0.
// - ROM checksum mismatch sets the ROM checksum flag.
// - flags read 1 on fault, reset to zero, cleared by writing one.
// - a fault is recorded only while its enable bit is set.
// - enable register at address 0x07, one enable bit per flag.
package ief_pkg;
  localparam int          ADDR_W        = 7;
  localparam int          DATA_W        = 16;
  localparam int          NFLAG         = 5;
  localparam logic [6:0]  ERR_ADDR      = 7'h06;
  localparam logic [6:0]  EN_ADDR       = 7'h07;
  localparam logic [6:0]  LAST_ADDR     = 7'h3F;
  localparam logic [15:0] EN_RESET      = 16'h0040;
  localparam logic [15:0] ERR_RESET     = 16'h0000;
  // flag bit positions in the status register
  localparam int          ROM_BIT       = 0;
  localparam int          MAP_BIT       = 1;
  localparam int          LINK_BIT      = 2;
  localparam int          WFLT_BIT      = 3;
  localparam int          RFLT_BIT      = 4;
  // checksum polynomial x^8+x^2+x+1
  localparam logic [7:0]  CRC_POLY      = 8'h07;
  localparam logic [7:0]  CRC_INIT      = 8'h00;
  // map check interval
  localparam int          CLK_MHZ       = 50;
  localparam int          MAP_CHECK_US  = 100;
  localparam int          MAP_CHECK_CYC = MAP_CHECK_US * CLK_MHZ;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ief_req_s;

  typedef enum logic [1:0] {IEF_ROM_RUN, IEF_ROM_CMP, IEF_ROM_DONE} ief_rom_e;
endpackage

//--- verilog/ief_flags.sv
// integrity error flag bank: status flags, enable register, map and ROM checks
// assumes the host controller presents decoded one-cycle accesses on clk
module ief_flags #(
  parameter int MAP_WORDS     = 8,
  parameter int ROM_WORDS     = 16,
  parameter logic [7:0] ROM_EXPECT = 8'h00,
  parameter int MAP_CHECK_CYC = ief_pkg::MAP_CHECK_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          ce,
  input  wire ief_pkg::ief_req_s             req,
  input  wire logic                          link_crc_fail,
  input  wire logic [MAP_WORDS*16-1:0]       map_image,
  input  wire logic [15:0]                   rom_data,
  output logic [$clog2(ROM_WORDS)-1:0]       rom_addr,
  output logic                               rom_check_done,
  output logic [ief_pkg::DATA_W-1:0]         rdata,
  output logic                               rvalid,
  output logic [ief_pkg::NFLAG-1:0]          flags
);
  import ief_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] crc_word(input logic [7:0] c, input logic [15:0] w);
    logic [7:0] r;
    r = c;
    for (int i = 15; i >= 0; i--)
    begin
      r = (r[7] ^ w[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return a <= LAST_ADDR;
  endfunction

  localparam int RA_W = $clog2(ROM_WORDS);
  localparam int TM_W = $clog2(MAP_CHECK_CYC + 1);

  logic [NFLAG-1:0]   flags_ff;
  logic [DATA_W-1:0]  en_ff;
  logic [DATA_W-1:0]  rdata_ff;
  logic               rvalid_ff;
  logic [NFLAG-1:0]   evt;
  logic [NFLAG-1:0]   clr;
  logic [NFLAG-1:0]   nxt_flags;
  logic               wr_err;
  logic               wr_en;

  // ----------------------------------------------------------------
  // map checksum
  // ----------------------------------------------------------------
  logic [7:0]         map_crc;
  logic [7:0]         base_ff;
  logic               resync_ff;
  logic [TM_W-1:0]    tmr_ff;
  logic               tick;
  logic               map_mismatch;

  always_comb
  begin
    map_crc = CRC_INIT;
    for (int i = 0; i < MAP_WORDS; i++)
    begin
      map_crc = crc_word(map_crc, map_image[i*16 +: 16]);
    end
  end

  assign tick         = en_ff[MAP_BIT] && tmr_ff == TM_W'(MAP_CHECK_CYC - 1);
  // a host write changes the image a cycle later, so the next tick is skipped
  assign map_mismatch = tick && !resync_ff && map_crc != base_ff;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      tmr_ff <= '0;
    else if (ce)
      tmr_ff <= (!en_ff[MAP_BIT] || tick) ? '0 : tmr_ff + 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      resync_ff <= 1'b1;
    else if (ce)
    begin
      if (req.wr && addr_ok(req.addr))
        resync_ff <= 1'b1;
      else if (tick || !en_ff[MAP_BIT])
        resync_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      base_ff <= CRC_INIT;
    else if (ce && (tick || !en_ff[MAP_BIT]))
      base_ff <= map_crc;
  end

  // ----------------------------------------------------------------
  // power-up ROM checksum
  // ----------------------------------------------------------------
  ief_rom_e           rom_st_ff;
  logic [RA_W-1:0]    rom_addr_ff;
  logic [7:0]         rom_crc_ff;
  logic               rom_bad;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rom_st_ff   <= IEF_ROM_RUN;
      rom_addr_ff <= '0;
      rom_crc_ff  <= CRC_INIT;
    end
    else if (ce)
    begin
      case (rom_st_ff)
        IEF_ROM_RUN:
        begin
          rom_crc_ff <= crc_word(rom_crc_ff, rom_data);
          if (rom_addr_ff == RA_W'(ROM_WORDS - 1))
            rom_st_ff <= IEF_ROM_CMP;
          else
            rom_addr_ff <= rom_addr_ff + 1'b1;
        end
        IEF_ROM_CMP:  rom_st_ff <= IEF_ROM_DONE;
        IEF_ROM_DONE: rom_st_ff <= IEF_ROM_DONE;
        default:      rom_st_ff <= IEF_ROM_DONE;
      endcase
    end
  end

  assign rom_bad = rom_st_ff == IEF_ROM_CMP && rom_crc_ff != ROM_EXPECT;

  // ----------------------------------------------------------------
  // flags and enables
  // ----------------------------------------------------------------
  assign wr_err = req.wr && req.addr == ERR_ADDR;
  assign wr_en  = req.wr && req.addr == EN_ADDR;

  always_comb
  begin
    evt           = '0;
    evt[RFLT_BIT] = req.rd && !addr_ok(req.addr);
    evt[WFLT_BIT] = req.wr && !addr_ok(req.addr);
    evt[LINK_BIT] = link_crc_fail;
    evt[MAP_BIT]  = map_mismatch;
    evt[ROM_BIT]  = rom_bad;
    clr           = wr_err ? req.wdata[NFLAG-1:0] : '0;
    // set beats a same-cycle clear; nothing else drops a flag
    nxt_flags     = (flags_ff & ~clr) | (evt & en_ff[NFLAG-1:0]);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flags_ff <= ERR_RESET[NFLAG-1:0];
    else if (ce)
      flags_ff <= nxt_flags;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      en_ff <= EN_RESET;
    else if (ce && wr_en)
      en_ff <= req.wdata;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_ff  <= '0;
      rvalid_ff <= 1'b0;
    end
    else if (ce)
    begin
      rvalid_ff <= req.rd;
      if (req.rd)
      begin
        if (req.addr == ERR_ADDR)
          rdata_ff <= {{(DATA_W-NFLAG){1'b0}}, flags_ff};
        else if (req.addr == EN_ADDR)
          rdata_ff <= en_ff;
        else
          rdata_ff <= '0;
      end
    end
  end

  assign flags          = flags_ff;
  assign rdata          = rdata_ff;
  assign rvalid         = rvalid_ff;
  assign rom_addr       = rom_addr_ff;
  assign rom_check_done = rom_st_ff == IEF_ROM_DONE;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_rd_fault_set: assert property (ce && req.rd && !addr_ok(req.addr) && en_ff[RFLT_BIT]
    |=> flags[RFLT_BIT]) else $error("read fault not flagged");
  a_wr_fault_set: assert property (ce && req.wr && !addr_ok(req.addr) && en_ff[WFLT_BIT]
    |=> flags[WFLT_BIT]) else $error("write fault not flagged");
  a_link_crc_set: assert property (ce && link_crc_fail && en_ff[LINK_BIT]
    |=> flags[LINK_BIT]) else $error("link checksum fault lost");
  a_map_tick_gap: assert property (ce && tick |=> !tick [*2])
    else $error("map check ticks too close");
  a_rom_done_time: assert property ($rose(nrst) |-> ##[1:300] rom_check_done)
    else $error("rom check did not finish");
  a_flag_w1c: assert property (ce && wr_err && req.wdata[LINK_BIT] && !link_crc_fail
    |=> !flags[LINK_BIT]) else $error("write one did not clear");
  a_gate_off: assert property (ce && !en_ff[RFLT_BIT] && !flags[RFLT_BIT]
    |=> !flags[RFLT_BIT]) else $error("disabled flag got set");
  a_en_write: assert property (ce && wr_en |=> en_ff == $past(req.wdata))
    else $error("enable register not written");
  a_flag_sticky: assert property (ce && flags[MAP_BIT] && !(wr_err && req.wdata[MAP_BIT])
    |=> flags[MAP_BIT]) else $error("flag dropped without clear");
endmodule

//--- tb/ief_host_model.sv
// host controller model: issues one-cycle register strobes
// assumes the bank answers a read one cycle after the strobe
module ief_host_model (
  input  wire logic          clk,
  input  wire logic          rvalid,
  input  wire logic [15:0]   rdata,
  output ief_pkg::ief_req_s  req
);
  timeunit 1ns;
  timeprecision 1ns;
  import ief_pkg::*;
  initial req = '0;
  // ----------------------------------------
  // access task
  // ----------------------------------------
  task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(negedge clk);
    req.rd = !w;
    req.wr = w;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    // no answer means unknown data, so a missing rvalid cannot pass
    q = rvalid ? rdata : 16'hXXXX;
    req.rd = 1'b0;
    req.wr = 1'b0;
    req.wdata = ~d;
  endtask
endmodule

//--- tb/tb_top.sv
// bench for the integrity error flag bank
// assumes the host model drives req; rom and map images come from here
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ief_pkg::*;
  logic          clk;
  logic          nrst;
  logic          ce;
  logic          link_crc_fail;
  logic          rvalid;
  logic          rom_check_done;
  logic [127:0]  map_image;
  logic [15:0]   rom_data;
  logic [15:0]   rdata;
  logic [15:0]   q;
  logic [3:0]    rom_addr;
  logic [4:0]    flags;
  ief_req_s      req;
  int            num_errors;
  int            tests_run;
  int            cyc;
  int            i;
  ief_flags #(.MAP_CHECK_CYC(20)) i_dut (.clk(clk), .nrst(nrst), .ce(ce), .req(req),
    .link_crc_fail(link_crc_fail), .map_image(map_image), .rom_data(rom_data),
    .rom_addr(rom_addr), .rom_check_done(rom_check_done), .rdata(rdata),
    .rvalid(rvalid), .flags(flags));
  ief_host_model i_host (.clk(clk), .rvalid(rvalid), .rdata(rdata), .req(req));
  // single nonzero word keeps the rom checksum away from zero
  assign rom_data = (rom_addr == 4'h0) ? 16'h0001 : 16'h0000;
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      num_errors++;
      results();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic rd(input logic [6:0] a);
    i_host.acc(1'b0, a, 16'h0000, q);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_host.acc(1'b1, a, d, q);
  endtask
  task automatic pulse_link();
    @(negedge clk);
    link_crc_fail = 1'b1;
    @(negedge clk);
    link_crc_fail = 1'b0;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    link_crc_fail = 1'b0;
    map_image = {8{16'hA5C3}};
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    rd(ERR_ADDR);
    chk("status reset", q, 16'h0000);
    rd(EN_ADDR);
    chk("enable reset", q, EN_RESET);
    wr(EN_ADDR, 16'h005F);
    rd(EN_ADDR);
    chk("enable write", q, 16'h005F);
    i = 0;
    while (rom_check_done !== 1'b1 && i < 100)
    begin
      @(negedge clk);
      i++;
    end
    chk("rom done", {15'h0000, rom_check_done}, 16'h0001);
    @(negedge clk);
    rd(ERR_ADDR);
    chk("rom flag", q, 16'h0001);
    wr(ERR_ADDR, 16'h0001);
    chk("rom clear", {11'h000, flags}, 16'h0000);
    rd(7'h40);
    chk("unmapped data", q, 16'h0000);
    wr(7'h7F, 16'hFFFF);
    repeat (5) @(negedge clk);
    chk("addr faults", {11'h000, flags}, 16'h0018);
    wr(ERR_ADDR, 16'h0008);
    chk("partial clear", {11'h000, flags}, 16'h0010);
    pulse_link();
    chk("link fault", {11'h000, flags}, 16'h0014);
    wr(ERR_ADDR, 16'h0014);
    // first tick after a write is skipped, so let it pass first
    repeat (25) @(negedge clk);
    map_image[20] = ~map_image[20];
    repeat (45) @(negedge clk);
    chk("map fault", {11'h000, flags}, 16'h0002);
    wr(ERR_ADDR, 16'h0002);
    // a link pulse while the clock enable is low must be lost
    @(negedge clk);
    ce = 1'b0;
    pulse_link();
    @(negedge clk);
    ce = 1'b1;
    chk("frozen link", {11'h000, flags}, 16'h0000);
    wr(EN_ADDR, 16'h0040);
    pulse_link();
    rd(7'h41);
    map_image[3] = ~map_image[3];
    repeat (45) @(negedge clk);
    chk("disabled", {11'h000, flags}, 16'h0000);
    // second reset in mid-run with a flag standing
    wr(EN_ADDR, 16'h005F);
    pulse_link();
    chk("link before reset", {11'h000, flags}, 16'h0004);
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk("flags in reset", {11'h000, flags}, 16'h0000);
    chk("done in reset", {15'h0000, rom_check_done}, 16'h0000);
    nrst = 1'b1;
    rd(ERR_ADDR);
    chk("status after reset", q, 16'h0000);
    rd(EN_ADDR);
    chk("enable after reset", q, EN_RESET);
    results();
  end
endmodule
